// ---- rtl/hdp_pkg.sv ----
// Constants and types for the dual-purpose host port and D-channel pin block
package hdp_pkg;
   // ==================================================================
   // Widths
   localparam int unsigned AD_W = 8;
   // ==================================================================
   // Register map of the small internal register set
   localparam logic [7:0] MCR_ADDR = 8'h00;
   localparam logic [7:0] ISR_ADDR = 8'h01;
   localparam logic [7:0] IMR_ADDR = 8'h02;
   localparam logic [7:0] DSTAT_ADDR = 8'h03;
   // ==================================================================
   // Field positions and reset values
   localparam int unsigned ALERT_SOURCE_BIT = 2;
   localparam logic [7:0] MCR_RESET = 8'h00;
   localparam logic [7:0] ISR_RESET = 8'h00;
   localparam logic [7:0] IMR_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;
   // ==================================================================
   // Line D-channel bit values and timing select default
   localparam logic LINE_MARK = 1'b1;
   localparam logic FLAG_FIRST_ZERO = 1'b0;
   localparam logic ADAPTIVE_DEFAULT = 1'b1;
   // ==================================================================
   // Types
   typedef enum logic {
      BUS_STROBE,
      BUS_SEPARATE
   } hdp_bus_mode_t;
   typedef enum logic [1:0] {
      DC_IDLE,
      DC_WAIT,
      DC_GRANT
   } hdp_dch_state_t;
endpackage : hdp_pkg

// ---- rtl/hdp_pin_port.sv ----
// Host microport and controllerless D-channel control pin logic
`timescale 1ns/10ps
// Behaviour
// - Mode pin high gives host port; low turns pins into control inputs and status.
// - Data strobe low at address strobe rise picks strobe-style, else separate-strobe.
// - Strobe-style: read-not-write 1 means read, 0 means write.
// - Separate-strobe: rw pin is write strobe, data strobe is read, as is latch.
// - Strobe-style: data strobe high marks valid write data or read drive.
// - Strobe-style: address captured from the bus at address strobe fall.
// - Host accesses are served only while the select pin is low.
// - Alert shows unmasked HDLC interrupt until status register read clears it.
// - Alert source bit 0 selects HDLC interrupt, 1 selects fresh data flag.
// - Fresh data flag pulls the alert pin low while new line data waits.
// - NT controllerless: timing pin 0 fixed timing, 1 adaptive.
// - D-in-B1 high routes all eight D bits through B1 instead of two.
// - While D-in-B1 is active, marks are sent in the line D-channel.
// - Control source pin 0 takes control from C-channel, 1 from pins.
// - With C-channel control, control pins are ignored, status stays valid.
// - With NT mode pin low, request high sends opening flag at once if free, else waits.
// - Request low sends continuous ones on the line D-channel.
// - Grant asserts after access won and first flag zero sent.
// - Grant released mid-packet means access lost; source must regain first.
module hdp_pin_port
   import hdp_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_mode_select,
   input wire logic i_nt_mode,
   input wire logic i_pin_rw_timing,
   input wire logic i_pin_data_strobe,
   input wire logic i_pin_addr_strobe,
   input wire logic i_pin_cs_dchan_request,
   input wire logic [AD_W-1:0] i_ad_in,
   output logic [AD_W-1:0] o_ad_out,
   output logic o_ad_oe,
   output logic o_pin13_out,
   output logic o_pin13_oe,
   input wire logic [AD_W-1:0] i_hdlc_event,
   input wire logic i_fresh_rx_data,
   input wire logic i_cchan_timing,
   input wire logic i_cchan_dchan_into_b1,
   input wire logic i_cchan_dchan_request,
   input wire logic i_dbit_tick,
   input wire logic i_dchan_free,
   input wire logic i_dchan_lost,
   input wire logic i_bp_dbit,
   output logic o_line_dbit,
   output logic o_b1_route8,
   output logic o_timing_adapt_select,
   output logic o_urgent_class_select,
   output logic o_control_source_select
);
   // ==================================================================
   // Pin synchronisers
   logic [13:0] pin_meta;
   logic [13:0] pin_sync;
   logic [13:0] pin_prev;
   logic [AD_W-1:0] ad_prev;

   // Two flops on every pin, then one more stage for edge detection
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pin_meta <= '0;
         pin_sync <= '0;
         pin_prev <= '0;
         ad_prev <= '0;
      end else begin
         // Each pin has its own bit; the bus byte sits below the strobes
         pin_meta <= {i_mode_select, i_nt_mode, i_pin_rw_timing, i_pin_data_strobe,
                      i_pin_addr_strobe, i_pin_cs_dchan_request, i_ad_in};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
         ad_prev <= pin_sync[AD_W-1:0];
      end
   end

   logic cmode_s, nt_s, rw_s, ds_s, as_s, cs_s;
   logic rw_p, ds_p, as_p;
   logic [AD_W-1:0] ad_s;
   assign cmode_s = pin_sync[13];
   assign nt_s = pin_sync[12];
   assign rw_s = pin_sync[11];
   assign ds_s = pin_sync[10];
   assign as_s = pin_sync[9];
   assign cs_s = pin_sync[8];
   assign ad_s = pin_sync[AD_W-1:0];
   assign rw_p = pin_prev[11];
   assign ds_p = pin_prev[10];
   assign as_p = pin_prev[9];

   // ==================================================================
   // Register state
   hdp_bus_mode_t bus_mode, next_bus_mode;
   hdp_dch_state_t dstate, next_dstate;
   logic [AD_W-1:0] addr, next_addr;
   logic [AD_W-1:0] mcr, next_mcr;
   logic [AD_W-1:0] isr, next_isr;
   logic [AD_W-1:0] imr, next_imr;

   // Read decode, shared by the output path and the checks
   function automatic logic [AD_W-1:0] reg_read(input logic [AD_W-1:0] a,
                                                input logic [AD_W-1:0] m,
                                                input logic [AD_W-1:0] s,
                                                input logic [AD_W-1:0] k,
                                                input hdp_dch_state_t d);
      logic [AD_W-1:0] r;
      r = READ_ZERO;
      case (a)
         MCR_ADDR: r = m;
         ISR_ADDR: r = s;
         IMR_ADDR: r = k;
         DSTAT_ADDR: r = {6'h00, d};
         default: r = READ_ZERO;
      endcase
      return r;
   endfunction

   // ==================================================================
   // Host bus decode
   logic host, ctl_less, sel, as_rise, as_fall, ds_fall, ds_rise, rw_rise;
   logic wr_commit, rd_end, rd_active;

   always_comb begin
      host = cmode_s;
      ctl_less = ~cmode_s;
      sel = host & ~cs_s;
      as_rise = as_s & ~as_p;
      as_fall = ~as_s & as_p;
      ds_fall = ~ds_s & ds_p;
      ds_rise = ds_s & ~ds_p;
      rw_rise = rw_s & ~rw_p;
      if (bus_mode == BUS_STROBE) begin
         wr_commit = sel & ds_fall & ~rw_s;
         rd_end = sel & ds_fall & rw_s;
         rd_active = sel & ds_s & rw_s;
      end else begin
         wr_commit = sel & rw_rise;
         rd_end = sel & ds_rise;
         rd_active = sel & ~ds_s;
      end
   end

   // Bus mode choice, address latch and register writes
   always_comb begin
      next_bus_mode = bus_mode;
      next_addr = addr;
      next_mcr = mcr;
      next_imr = imr;
      next_isr = isr;
      if (host && as_rise) begin
         next_bus_mode = ds_s ? BUS_SEPARATE : BUS_STROBE;
      end
      if (host && as_fall) begin
         next_addr = ad_s;
      end
      if (wr_commit && addr == MCR_ADDR) begin
         next_mcr = ad_prev;
      end
      if (wr_commit && addr == IMR_ADDR) begin
         next_imr = ad_prev;
      end
      // Clear only what the host saw; a new event in the same cycle wins
      if (rd_end && addr == ISR_ADDR) begin
         next_isr = isr & ~o_ad_out;
      end
      next_isr = next_isr | i_hdlc_event;
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bus_mode <= BUS_STROBE;
         addr <= '0;
         mcr <= MCR_RESET;
         isr <= ISR_RESET;
         imr <= IMR_RESET;
      end else begin
         bus_mode <= next_bus_mode;
         addr <= next_addr;
         mcr <= next_mcr;
         isr <= next_isr;
         imr <= next_imr;
      end
   end

   // ==================================================================
   // Controllerless control source and D-channel access
   logic pins_ctl, timing, dchan_into_b1, dchan_request;
   logic next_line_dbit, next_b1_route8, next_timing, next_urgent, next_ctl_src;
   logic next_pin13_oe, alert;
   logic [AD_W-1:0] next_ad_out;
   logic next_ad_oe;

   always_comb begin
      pins_ctl = ctl_less & as_s;
      timing = pins_ctl ? rw_s : i_cchan_timing;
      dchan_into_b1 = ctl_less & (pins_ctl ? ds_s : i_cchan_dchan_into_b1);
      dchan_request = ctl_less & ~nt_s & (pins_ctl ? cs_s : i_cchan_dchan_request);
      next_dstate = dstate;
      next_line_dbit = o_line_dbit;
      case (dstate)
         DC_IDLE: begin
            if (dchan_request && !dchan_into_b1) begin
               next_dstate = DC_WAIT;
            end
         end
         DC_WAIT: begin
            if (!dchan_request || dchan_into_b1) begin
               next_dstate = DC_IDLE;
            end else if (i_dbit_tick && i_dchan_free) begin
               next_dstate = DC_GRANT;
            end
         end
         DC_GRANT: begin
            if (!dchan_request || dchan_into_b1) begin
               next_dstate = DC_IDLE;
            end else if (i_dchan_lost) begin
               next_dstate = DC_WAIT;
            end
         end
         default: next_dstate = DC_IDLE;
      endcase
      if (i_dbit_tick) begin
         if (dchan_into_b1 || !dchan_request) begin
            next_line_dbit = LINE_MARK;
         end else if (dstate == DC_WAIT && i_dchan_free) begin
            next_line_dbit = FLAG_FIRST_ZERO;
         end else if (dstate == DC_GRANT && !i_dchan_lost) begin
            next_line_dbit = i_bp_dbit;
         end else begin
            next_line_dbit = LINE_MARK;
         end
      end
      next_b1_route8 = dchan_into_b1;
      next_timing = (ctl_less && nt_s) ? timing : ADAPTIVE_DEFAULT;
      next_urgent = ctl_less & ~nt_s & timing;
      next_ctl_src = pins_ctl;
      alert = mcr[ALERT_SOURCE_BIT] ? i_fresh_rx_data : |(isr & imr);
      next_pin13_oe = host ? alert : (next_dstate == DC_GRANT);
      next_ad_out = reg_read(addr, mcr, isr, imr, dstate);
      next_ad_oe = rd_active;
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dstate <= DC_IDLE;
         o_line_dbit <= LINE_MARK;
         o_b1_route8 <= 1'b0;
         o_timing_adapt_select <= ADAPTIVE_DEFAULT;
         o_urgent_class_select <= 1'b0;
         o_control_source_select <= 1'b0;
         o_pin13_oe <= 1'b0;
         o_pin13_out <= 1'b0;
         o_ad_out <= '0;
         o_ad_oe <= 1'b0;
      end else begin
         dstate <= ctl_less ? next_dstate : DC_IDLE;
         o_line_dbit <= next_line_dbit;
         o_b1_route8 <= next_b1_route8;
         o_timing_adapt_select <= next_timing;
         o_urgent_class_select <= next_urgent;
         o_control_source_select <= next_ctl_src;
         o_pin13_oe <= next_pin13_oe;
         o_pin13_out <= 1'b0;
         o_ad_out <= next_ad_out;
         o_ad_oe <= next_ad_oe;
      end
   end

   // ==================================================================
   // Checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);

   chk_bus_mode_pick: assert property (
      host && as_rise |=> bus_mode == ($past(ds_s) ? BUS_SEPARATE : BUS_STROBE))
      else $error("bus mode not taken from data strobe");
   chk_addr_latch: assert property (
      host && as_fall |=> addr == $past(ad_s))
      else $error("address not latched at strobe fall");
   chk_rw_write: assert property (
      bus_mode == BUS_STROBE && sel && ds_fall && !rw_s && addr == MCR_ADDR
      |=> mcr == $past(ad_prev))
      else $error("strobe-style write lost");
   chk_sep_read_drive: assert property (
      bus_mode == BUS_SEPARATE && sel && !ds_s && !as_rise |=> o_ad_oe)
      else $error("read strobe did not drive bus");
   chk_ds_read_data: assert property (
      host && bus_mode == BUS_STROBE && sel && ds_s && rw_s
      |=> o_ad_oe && o_ad_out == $past(reg_read(addr, mcr, isr, imr, dstate)))
      else $error("read data not driven");
   chk_select_gate: assert property (
      cs_s || !host |=> !o_ad_oe)
      else $error("bus driven while unselected");
   chk_alert_hold: assert property (
      host && !mcr[ALERT_SOURCE_BIT] && (|(isr & imr)) |=> o_pin13_oe)
      else $error("alert dropped while pending");
   chk_status_clear: assert property (
      rd_end && addr == ISR_ADDR && i_hdlc_event == 8'h00
      |=> (isr & $past(o_ad_out)) == 8'h00)
      else $error("status read did not clear");
   chk_fresh_flag: assert property (
      host && mcr[ALERT_SOURCE_BIT] |=> o_pin13_oe == $past(i_fresh_rx_data))
      else $error("fresh data flag not on alert");
   chk_marks_in_b1: assert property (
      dchan_into_b1 && i_dbit_tick |=> o_line_dbit && o_b1_route8)
      else $error("no marks while routed to B1");
   chk_ones_idle: assert property (
      !dchan_request && i_dbit_tick |=> o_line_dbit)
      else $error("ones not sent without request");
   chk_grant_zero: assert property (
      ctl_less && dstate == DC_WAIT && dchan_request && !dchan_into_b1 && i_dbit_tick && i_dchan_free
      |=> !o_line_dbit && dstate == DC_GRANT && o_pin13_oe)
      else $error("grant without first flag zero");
   chk_grant_lost: assert property (
      ctl_less && dstate == DC_GRANT && dchan_request && !dchan_into_b1 && i_dchan_lost
      |=> dstate == DC_WAIT ##0 !o_pin13_oe)
      else $error("grant held after loss");
   chk_serial_source: assert property (
      ctl_less && !as_s |=> o_b1_route8 == $past(i_cchan_dchan_into_b1))
      else $error("control pins not ignored");
   chk_fixed_timing: assert property (
      ctl_less && nt_s && as_s |=> o_timing_adapt_select == $past(rw_s))
      else $error("timing select not applied");

   cov_host_read: cover property (rd_end && addr == ISR_ADDR);
   cov_grant_won: cover property (dstate == DC_WAIT ##1 dstate == DC_GRANT);
   cov_grant_lost: cover property (dstate == DC_GRANT ##1 dstate == DC_WAIT);
   cov_sep_mode: cover property (bus_mode == BUS_SEPARATE && wr_commit);
endmodule // hdp_pin_port

// ---- dv/hdp_packet_src.sv ----
// Packet source and pull-up model at the far side of the D-channel pins
`timescale 1ns/10ps
module hdp_packet_src (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_free,
   input wire logic i_pin13_oe,
   input wire logic i_pin13_out,
   output logic o_tick,
   output logic o_free,
   output logic o_bp_dbit,
   output logic o_pin13_level
);
   logic [2:0] div;
   logic [7:0] pkt;
   // ==================================================================
   // Pin level and channel state
   assign o_pin13_level = i_pin13_oe ? i_pin13_out : 1'b1;
   assign o_free = i_free;
   // ==================================================================
   // One line bit every eight clocks; packet bits only once granted
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         div <= 3'h0;
         pkt <= 8'hb4;
         o_tick <= 1'b0;
         o_bp_dbit <= 1'b0;
      end else begin
         div <= div + 3'h1;
         o_tick <= (div == 3'h7);
         if (o_pin13_level) begin
            pkt <= 8'hb4;
            o_bp_dbit <= !o_bp_dbit;
         end else if (o_tick) begin
            pkt <= {pkt[6:0], pkt[7]};
            o_bp_dbit <= pkt[7];
         end
      end
   end
endmodule // hdp_packet_src

// ---- dv/host_port_and_dchan_control_pins_tb_top.sv ----
// Self-checking bench for the host port and D-channel pin block
`timescale 1ns/10ps
module host_port_and_dchan_control_pins_tb_top;
   import hdp_pkg::*;
   logic clk, rst_n, msel, nt, rw, ds, as_p, cs, fresh, cc_t, cc_b, cc_r, lost, free_req;
   logic [7:0] ad, hev, ad_out, rd;
   logic oe, p13_out, p13_oe, line, r8, tsel, usel, csrc, tick, free, bp, lvl, rd_oe, bp_seen;
   int fail_count, checks_done;
   hdp_pin_port dut (.i_clock(clk), .i_reset_n(rst_n), .i_mode_select(msel), .i_nt_mode(nt),
      .i_pin_rw_timing(rw), .i_pin_data_strobe(ds), .i_pin_addr_strobe(as_p),
      .i_pin_cs_dchan_request(cs), .i_ad_in(ad), .o_ad_out(ad_out), .o_ad_oe(oe),
      .o_pin13_out(p13_out), .o_pin13_oe(p13_oe), .i_hdlc_event(hev), .i_fresh_rx_data(fresh),
      .i_cchan_timing(cc_t), .i_cchan_dchan_into_b1(cc_b), .i_cchan_dchan_request(cc_r),
      .i_dbit_tick(tick), .i_dchan_free(free), .i_dchan_lost(lost), .i_bp_dbit(bp),
      .o_line_dbit(line), .o_b1_route8(r8), .o_timing_adapt_select(tsel),
      .o_urgent_class_select(usel), .o_control_source_select(csrc));
   hdp_packet_src src (.i_clock(clk), .i_reset_n(rst_n), .i_free(free_req), .i_pin13_oe(p13_oe),
      .i_pin13_out(p13_out), .o_tick(tick), .o_free(free), .o_bp_dbit(bp), .o_pin13_level(lvl));
   // ==================================================================
   // Clock and helpers
   always #20 clk = ~clk;
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk1(input string what, input logic exp, input logic got);
      check(what, {7'h0, exp}, {7'h0, got});
   endtask
   task automatic look(input int n);
      step(n);
      @(negedge clk);
   endtask
   // One host access; sep picks separate strobes, the idle data strobe level sets the mode
   task automatic acc(input logic sep, input logic wr, input logic [7:0] a, input logic [7:0] d);
      ds <= sep;
      step(3);
      ad <= a;
      as_p <= 1'b1;
      step(3);
      as_p <= 1'b0;
      step(3);
      if (wr) begin
         ad <= d;
         rw <= 1'b0;
         ds <= 1'b1;
         step(3);
         rw <= sep;
         ds <= sep;
         step(3);
         rw <= 1'b1;
         ds <= sep;
         step(3);
      end else begin
         ds <= !sep;
         look(4);
         rd_oe = oe;
         rd = ad_out;
         @(posedge clk);
         ds <= sep;
         step(4);
      end
   endtask
   task automatic rd_chk(input logic sep, input logic [7:0] a, input logic [7:0] exp);
      acc(sep, 1'b0, a, 8'h00);
      chk1("read drive", 1'b1, rd_oe);
      check("read data", exp, rd);
   endtask
   task automatic pulse(input logic [7:0] ev);
      hev <= ev;
      step(1);
      hev <= 8'h00;
   endtask
   task automatic at_tick;
      int n;
      n = 0;
      @(negedge clk);
      while (tick !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      bp_seen = bp;
      @(negedge clk);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ==================================================================
   // Watchdog sized well above the longest expected run
   initial begin
      repeat (6000) @(posedge clk);
      fail_count++;
      $display("watchdog expired");
      test_done;
   end
   // ==================================================================
   // Test sequence
   initial begin
      {clk, rst_n, nt, ds, as_p, cs, fresh, cc_b, cc_r, lost, free_req} = '0;
      {msel, rw, cc_t} = 3'b111;
      ad = 8'h00;
      hev = 8'h00;
      look(2);
      chk1("reset drive", 1'b0, oe);
      chk1("reset pin13", 1'b0, p13_oe);
      chk1("reset line", 1'b1, line);
      chk1("reset timing", 1'b1, tsel);
      step(2);
      rst_n <= 1'b1;
      step(4);
      acc(0, 1, IMR_ADDR, 8'h05);
      rd_chk(0, IMR_ADDR, 8'h05);
      rd_chk(0, 8'h07, READ_ZERO);
      cs <= 1'b1;
      acc(0, 1, IMR_ADDR, 8'hff);
      acc(0, 0, IMR_ADDR, 8'h00);
      chk1("deselected drive", 1'b0, rd_oe);
      cs <= 1'b0;
      rd_chk(0, IMR_ADDR, 8'h05);
      $display("test host registers done");
      pulse(8'h02);
      look(3);
      chk1("masked alert", 1'b0, p13_oe);
      pulse(8'h04);
      look(2);
      chk1("alert", 1'b1, p13_oe);
      chk1("alert level", 1'b0, lvl);
      rd_chk(0, ISR_ADDR, 8'h06);
      look(2);
      chk1("alert cleared", 1'b0, p13_oe);
      acc(0, 1, MCR_ADDR, 8'h01 << ALERT_SOURCE_BIT);
      fresh <= 1'b1;
      look(2);
      chk1("fresh data", 1'b1, p13_oe);
      fresh <= 1'b0;
      pulse(8'h04);
      look(3);
      chk1("hdlc hidden", 1'b0, p13_oe);
      acc(0, 1, MCR_ADDR, MCR_RESET);
      look(2);
      chk1("hdlc shown", 1'b1, p13_oe);
      rd_chk(0, ISR_ADDR, 8'h04);
      $display("test alert done");
      acc(1, 1, IMR_ADDR, 8'h3c);
      rd_chk(1, IMR_ADDR, 8'h3c);
      rd_chk(0, IMR_ADDR, 8'h3c);
      $display("test bus modes done");
      {msel, nt, as_p, rw, ds} <= 5'b01101;
      look(4);
      chk1("fixed timing", 1'b0, tsel);
      chk1("b1 routing", 1'b1, r8);
      chk1("pin source", 1'b1, csrc);
      chk1("no drive", 1'b0, oe);
      at_tick();
      chk1("marks", 1'b1, line);
      {rw, ds} <= 2'b10;
      look(4);
      chk1("adaptive", 1'b1, tsel);
      chk1("b1 off", 1'b0, r8);
      {as_p, cc_t, cc_b} <= 3'b001;
      look(4);
      chk1("serial source", 1'b0, csrc);
      chk1("serial timing", 1'b0, tsel);
      chk1("serial b1", 1'b1, r8);
      {as_p, cc_t, cc_b, nt} <= 4'b1100;
      $display("test controllerless done");
      look(4);
      chk1("urgent class", 1'b1, usel);
      repeat (2) begin
         at_tick();
         chk1("idle ones", 1'b1, line);
      end
      cs <= 1'b1;
      repeat (3) begin
         at_tick();
         chk1("busy wait", 1'b0, p13_oe);
      end
      free_req <= 1'b1;
      at_tick();
      chk1("flag zero", FLAG_FIRST_ZERO, line);
      chk1("granted", 1'b1, p13_oe);
      repeat (8) begin
         at_tick();
         chk1("packet bit", bp_seen, line);
      end
      {lost, free_req} <= 2'b10;
      look(2);
      chk1("lost grant", 1'b0, p13_oe);
      {lost, free_req} <= 2'b01;
      at_tick();
      chk1("regained", 1'b1, p13_oe);
      cs <= 1'b0;
      at_tick();
      at_tick();
      chk1("release", 1'b0, p13_oe);
      chk1("ones again", 1'b1, line);
      $display("test dchannel done");
      test_done;
   end
endmodule // host_port_and_dchan_control_pins_tb_top
